// [ttpwm_pkg.sv]
// Constants, field layouts and carrier types for the timer and triple PWM block.
// Assumes a 50 MHz pclk and an APB master with 32-bit data.
package ttpwm_pkg;

  // Printed offsets are register indices; byte address is 4 * (index - base).
  localparam logic [31:0] REG_BASE = 32'h5000_3400;
  localparam logic [31:0] IDX_TIMER_CONTROL = 32'h5000_3400;
  localparam logic [31:0] IDX_ON_PERIOD = 32'h5000_3402;
  localparam logic [31:0] IDX_HIGH_RELOAD = 32'h5000_3404;
  localparam logic [31:0] IDX_LOW_RELOAD = 32'h5000_3406;
  localparam logic [31:0] IDX_CHANNEL_A_DUTY = 32'h5000_3408;
  localparam logic [31:0] IDX_CHANNEL_B_DUTY = 32'h5000_340a;
  localparam logic [31:0] IDX_CHANNEL_C_DUTY = 32'h5000_340c;
  localparam logic [31:0] IDX_SHARED_PERIOD = 32'h5000_340e;
  localparam logic [31:0] IDX_THREE_CH_CONTROL = 32'h5000_3410;
  localparam int ADDR_W = 8;

  // Control field positions.
  localparam int TC_RUN_BIT = 0;
  localparam int TC_FAST_BIT = 1;
  localparam int TC_BYPASS_BIT = 2;
  localparam int TC_STYLE_BIT = 3;
  localparam int PC_ENABLE_BIT = 0;
  localparam int PC_SW_PAUSE_BIT = 1;
  localparam int PC_HW_ALLOW_BIT = 2;

  // Reset values.
  localparam logic [15:0] TIMER_CONTROL_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [13:0] DUTY_RST = 14'h0000;
  localparam logic [13:0] PERIOD_RST = 14'h0000;
  localparam logic [2:0] THREE_CH_CONTROL_RST = 3'h4;

  // Timing.
  localparam int PCLK_HZ = 50_000_000;
  localparam int SLOW_CLK_HZ = 32_000;
  localparam int FAST_CLK_HZ = 2_000_000;
  localparam int SLOW_DIV = PCLK_HZ / SLOW_CLK_HZ;
  localparam int FAST_DIV = PCLK_HZ / FAST_CLK_HZ;
  localparam int PRESCALE = 10;
  localparam int DUTY_W = 14;

  typedef struct packed {
    logic style;
    logic bypass;
    logic fast_sel;
    logic run;
  } ttpwm_tctrl_t;

  typedef struct packed {
    logic hw_allow;
    logic sw_pause;
    logic enable;
  } ttpwm_pctrl_t;

endpackage

// [ttpwm_tb_top.sv]
// Self-checking testbench for the timer and triple PWM block, driven over APB.
// Assumes the package constants and the byte address rule 4 * (index - base).
`timescale 1ns/1ps
`default_nettype none
module ttpwm_tb_top;
  // Short dividers keep the run brief; every timer expectation is derived from them.
  localparam int SDIV = 4;
  localparam int FDIV = 2;
  localparam int PDIV = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hw_pause_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic t_high, t_low, ch_a, ch_b, ch_c;
  logic [4:0] outs;
  int compares = 0;
  int miscompares = 0;
  logic [31:0] regs [9] = '{ttpwm_pkg::IDX_TIMER_CONTROL, ttpwm_pkg::IDX_ON_PERIOD,
    ttpwm_pkg::IDX_HIGH_RELOAD, ttpwm_pkg::IDX_LOW_RELOAD, ttpwm_pkg::IDX_CHANNEL_A_DUTY,
    ttpwm_pkg::IDX_CHANNEL_B_DUTY, ttpwm_pkg::IDX_CHANNEL_C_DUTY,
    ttpwm_pkg::IDX_SHARED_PERIOD, ttpwm_pkg::IDX_THREE_CH_CONTROL};
  assign outs = {ch_c, ch_b, ch_a, t_low, t_high};

  ttpwm_top #(.SLOW_DIV(SDIV), .FAST_DIV(FDIV), .PRESCALE(PDIV)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_pause_pin(hw_pause_pin), .timer_high_output(t_high), .timer_low_output(t_low),
    .channel_a_output(ch_a), .channel_b_output(ch_b), .channel_c_output(ch_c));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Called just after a rising edge; leaves one idle cycle so signals never double-assign.
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= 8'((idx - ttpwm_pkg::REG_BASE) << 2);
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [31:0] idx, output logic [31:0] r);
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
  endtask

  task automatic rdc(input string what, input logic [31:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    rd(idx, r);
    check(what, r, exp);
  endtask

  // Samples one output for n cycles: high count, longest high run and toggles.
  task automatic measure(input int sel, input int n, output int hi, output int run,
                         output int tog);
    int cur;
    logic prev;
    logic now;
    hi = 0;
    run = 0;
    tog = 0;
    cur = 0;
    @(posedge pclk);
    prev = outs[sel];
    repeat (n) begin
      @(posedge pclk);
      now = outs[sel];
      if (now === 1'b1) begin
        hi++;
        cur++;
      end else begin
        cur = 0;
      end
      if (cur > run) run = cur;
      if (now !== prev) tog++;
      prev = now;
    end
  endtask

  // Restarting from the stopped state avoids a half phase at the old rate.
  task automatic timer_run(input logic [31:0] ctrl, input int hexp, input int lexp,
                           input int win);
    int hi, run, tog;
    wr(ttpwm_pkg::IDX_TIMER_CONTROL, 32'h0);
    wr(ttpwm_pkg::IDX_TIMER_CONTROL, ctrl);
    measure(0, win, hi, run, tog);
    check("high output run", run, hexp);
    measure(1, win, hi, run, tog);
    check("low output run", run, lexp);
  endtask

  // A negative expectation skips that comparison, as a frozen level may be either value.
  task automatic pwm_chk(input logic [31:0] ctrl, input logic pin, input int atog,
                         input int ahi, input int chi);
    int hi, run, tog;
    wr(ttpwm_pkg::IDX_THREE_CH_CONTROL, ctrl);
    hw_pause_pin <= pin;
    repeat (8) @(posedge pclk);
    measure(2, 40, hi, run, tog);
    check("channel a toggles", tog, atog);
    if (ahi >= 0) check("channel a high", hi, ahi);
    measure(3, 40, hi, run, tog);
    check("channel b high", hi, 0);
    measure(4, 40, hi, run, tog);
    if (chi >= 0) check("channel c high", hi, chi);
  endtask

  initial begin
    logic [31:0] v1, v2;
    logic e;
    int hi, run, tog;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hw_pause_pin = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rdc("reset value", regs[i], (i == 8) ? 32'h4 : 32'h0);
    for (int i = 4; i < 8; i++) begin
      wr(regs[i], 32'hffff_ffff);
      rdc("fourteen bit field", regs[i], 32'h0000_3fff);
    end
    apb(1'b1, 32'h5000_3411, 32'h1234, v1, e);
    check("unmapped error", e, 1);
    apb(1'b0, 32'h5000_3411, 32'h0, v1, e);
    check("unmapped read", v1, 0);
    wr(ttpwm_pkg::IDX_ON_PERIOD, 32'h5);
    wr(ttpwm_pkg::IDX_HIGH_RELOAD, 32'h3);
    wr(ttpwm_pkg::IDX_LOW_RELOAD, 32'h2);
    rdc("on counter held", ttpwm_pkg::IDX_ON_PERIOD, 32'h5);
    rdc("high read held", ttpwm_pkg::IDX_HIGH_RELOAD, 32'h3);
    rdc("low read held", ttpwm_pkg::IDX_LOW_RELOAD, 32'h3);
    measure(0, 30, hi, run, tog);
    check("stopped output", hi, 0);
    timer_run(32'h3, 4 * FDIV, 3 * FDIV, 40);
    timer_run(32'h1, 4 * SDIV, 3 * SDIV, 80);
    timer_run(32'hb, FDIV, FDIV, 40);
    rd(ttpwm_pkg::IDX_HIGH_RELOAD, v1);
    check("live phase count", {31'h0, v1 <= 32'h3}, 1);
    rd(ttpwm_pkg::IDX_LOW_RELOAD, v1);
    check("live phase count", {31'h0, v1 <= 32'h3}, 1);
    wr(ttpwm_pkg::IDX_TIMER_CONTROL, 32'h0);
    measure(1, 30, hi, run, tog);
    check("stopped low output", hi, 0);
    // Forty cycles between the two samples are twenty timer ticks.
    wr(ttpwm_pkg::IDX_ON_PERIOD, 32'hffff);
    wr(ttpwm_pkg::IDX_TIMER_CONTROL, 32'h7);
    rd(ttpwm_pkg::IDX_ON_PERIOD, v1);
    repeat (37) @(posedge pclk);
    rd(ttpwm_pkg::IDX_ON_PERIOD, v2);
    check("on ticks undivided", {31'h0, (v1 - v2) inside {[19:21]}}, 1);
    timer_run(32'h3, 4 * FDIV, 3 * FDIV, 40);
    rd(ttpwm_pkg::IDX_ON_PERIOD, v1);
    repeat (37) @(posedge pclk);
    rd(ttpwm_pkg::IDX_ON_PERIOD, v2);
    check("on ticks divided", {31'h0, (v1 - v2) inside {[1:3]}}, 1);
    wr(ttpwm_pkg::IDX_SHARED_PERIOD, 32'h3);
    wr(ttpwm_pkg::IDX_CHANNEL_A_DUTY, 32'h2);
    wr(ttpwm_pkg::IDX_CHANNEL_B_DUTY, 32'h0);
    wr(ttpwm_pkg::IDX_CHANNEL_C_DUTY, 32'h4);
    pwm_chk(32'h5, 1'b0, 20, 20, 40);
    pwm_chk(32'h7, 1'b0, 0, -1, 40);
    pwm_chk(32'h5, 1'b0, 20, 20, 40);
    pwm_chk(32'h5, 1'b1, 0, -1, -1);
    pwm_chk(32'h1, 1'b1, 20, 20, 40);
    pwm_chk(32'h4, 1'b0, 0, 0, 0);
    give_verdict();
  end

  // The tests need about 1500 cycles; this bound only cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire

// [ttpwm_top.sv]
// Timer with prescaled on counter and phase counter, plus triple PWM, behind APB.
// Assumes one 50 MHz pclk; slow and fast timer clocks are enable pulses from dividers.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ttpwm_top #(
  parameter int SLOW_DIV = ttpwm_pkg::SLOW_DIV,
  parameter int FAST_DIV = ttpwm_pkg::FAST_DIV,
  parameter int PRESCALE = ttpwm_pkg::PRESCALE
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ttpwm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins.
  input wire logic hw_pause_pin,
  output logic timer_high_output,
  output logic timer_low_output,
  output logic channel_a_output,
  output logic channel_b_output,
  output logic channel_c_output
);
  localparam int W = ttpwm_pkg::DUTY_W;
  localparam int SW = $clog2(SLOW_DIV + 1);
  localparam int FW = $clog2(FAST_DIV + 1);
  localparam int PW = $clog2(PRESCALE + 1);

  function automatic logic [ttpwm_pkg::ADDR_W-1:0] byte_addr(input logic [31:0] idx);
    logic [31:0] d;
    d = (idx - ttpwm_pkg::REG_BASE) << 2;
    return d[ttpwm_pkg::ADDR_W-1:0];
  endfunction

  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_TC = byte_addr(ttpwm_pkg::IDX_TIMER_CONTROL);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_ON = byte_addr(ttpwm_pkg::IDX_ON_PERIOD);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_HI = byte_addr(ttpwm_pkg::IDX_HIGH_RELOAD);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_LO = byte_addr(ttpwm_pkg::IDX_LOW_RELOAD);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_DA = byte_addr(ttpwm_pkg::IDX_CHANNEL_A_DUTY);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_DB = byte_addr(ttpwm_pkg::IDX_CHANNEL_B_DUTY);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_DC = byte_addr(ttpwm_pkg::IDX_CHANNEL_C_DUTY);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_PER = byte_addr(ttpwm_pkg::IDX_SHARED_PERIOD);
  localparam logic [ttpwm_pkg::ADDR_W-1:0] A_PC = byte_addr(ttpwm_pkg::IDX_THREE_CH_CONTROL);

  // Registers.
  ttpwm_pkg::ttpwm_tctrl_t tctrl_reg;
  ttpwm_pkg::ttpwm_pctrl_t pctrl_reg;
  logic [15:0] on_period_value_reg;
  logic [15:0] high_phase_value_reg;
  logic [15:0] low_phase_value_reg;
  logic [W-1:0] duty_a_reg;
  logic [W-1:0] duty_b_reg;
  logic [W-1:0] duty_c_reg;
  logic [W-1:0] period_reg;

  // Timer state.
  logic [15:0] on_period_counter_reg;
  logic [15:0] phase_counter_reg;
  logic high_phase_reg;
  logic [SW-1:0] slow_div_reg;
  logic [FW-1:0] fast_div_reg;
  logic [PW-1:0] pre_reg;
  logic half_fast_reg;
  logic timer_high_output_reg;
  logic timer_low_output_reg;

  // Bus decode.
  logic wr_en;
  logic setup;
  logic mapped;
  logic [31:0] rd_next;
  logic [31:0] prdata_reg;
  logic slverr_reg;

  // Ticks.
  logic slow_tick;
  logic fast_tick;
  logic timer_tick;
  logic on_tick;

  // Hardware pause synchroniser and PWM outputs.
  logic hwp_meta_reg;
  logic hwp_sync_reg;
  logic [2:0] pwm_out;

  // Access phase is always one cycle, so pready simply follows penable.
  assign pready = psel & penable;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & mapped;
  assign prdata = prdata_reg;
  assign pslverr = pready & slverr_reg;

  always_comb begin
    mapped = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr)
      A_TC: rd_next = {28'h000_0000, tctrl_reg};
      A_ON: rd_next = {16'h0000, on_period_counter_reg};
      A_HI: rd_next = {16'h0000, phase_counter_reg};
      A_LO: rd_next = {16'h0000, phase_counter_reg};
      A_DA: rd_next = {18'h0_0000, duty_a_reg};
      A_DB: rd_next = {18'h0_0000, duty_b_reg};
      A_DC: rd_next = {18'h0_0000, duty_c_reg};
      A_PER: rd_next = {18'h0_0000, period_reg};
      A_PC: rd_next = {29'h0000_0000, pctrl_reg};
      default: mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle, so reads see state one edge before the access edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
      slverr_reg <= ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctrl_reg <= ttpwm_pkg::TIMER_CONTROL_RST[3:0];
      pctrl_reg <= ttpwm_pkg::THREE_CH_CONTROL_RST;
    end else if (wr_en && paddr == A_TC) begin
      tctrl_reg <= pwdata[3:0];
    end else if (wr_en && paddr == A_PC) begin
      pctrl_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_period_value_reg <= ttpwm_pkg::RELOAD_RST;
      high_phase_value_reg <= ttpwm_pkg::RELOAD_RST;
      low_phase_value_reg <= ttpwm_pkg::RELOAD_RST;
    end else if (wr_en) begin
      if (paddr == A_ON) on_period_value_reg <= pwdata[15:0];
      if (paddr == A_HI) high_phase_value_reg <= pwdata[15:0];
      if (paddr == A_LO) low_phase_value_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_a_reg <= ttpwm_pkg::DUTY_RST;
      duty_b_reg <= ttpwm_pkg::DUTY_RST;
      duty_c_reg <= ttpwm_pkg::DUTY_RST;
      period_reg <= ttpwm_pkg::PERIOD_RST;
    end else if (wr_en) begin
      if (paddr == A_DA) duty_a_reg <= pwdata[W-1:0];
      if (paddr == A_DB) duty_b_reg <= pwdata[W-1:0];
      if (paddr == A_DC) duty_c_reg <= pwdata[W-1:0];
      if (paddr == A_PER) period_reg <= pwdata[W-1:0];
    end
  end

  // Slow and fast rate dividers run freely so the halved fast clock keeps its phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_div_reg <= '0;
      fast_div_reg <= '0;
    end else begin
      slow_div_reg <= slow_tick ? '0 : slow_div_reg + 1'b1;
      fast_div_reg <= fast_tick ? '0 : fast_div_reg + 1'b1;
    end
  end

  assign slow_tick = slow_div_reg == SW'(SLOW_DIV - 1);
  assign fast_tick = fast_div_reg == FW'(FAST_DIV - 1);
  assign timer_tick = tctrl_reg.fast_sel ? fast_tick : slow_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= '0;
    end else if (!tctrl_reg.run) begin
      pre_reg <= '0;
    end else if (timer_tick) begin
      pre_reg <= (pre_reg == PW'(PRESCALE - 1)) ? '0 : pre_reg + 1'b1;
    end
  end

  // Only the on counter sees the divided rate; the phase counter uses timer_tick.
  assign on_tick = timer_tick && (tctrl_reg.bypass || pre_reg == PW'(PRESCALE - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_period_counter_reg <= 16'h0000;
    end else if (!tctrl_reg.run) begin
      on_period_counter_reg <= on_period_value_reg;
    end else if (on_tick) begin
      on_period_counter_reg <= (on_period_counter_reg == 16'h0000) ?
        on_period_value_reg : on_period_counter_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_counter_reg <= 16'h0000;
      high_phase_reg <= 1'b1;
    end else if (!tctrl_reg.run) begin
      phase_counter_reg <= high_phase_value_reg;
      high_phase_reg <= 1'b1;
    end else if (timer_tick) begin
      if (phase_counter_reg == 16'h0000) begin
        phase_counter_reg <= high_phase_reg ? low_phase_value_reg : high_phase_value_reg;
        high_phase_reg <= ~high_phase_reg;
      end else begin
        phase_counter_reg <= phase_counter_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_fast_reg <= 1'b0;
    end else if (fast_tick) begin
      half_fast_reg <= ~half_fast_reg;
    end
  end

  // The low output mirrors the high output in the opposite phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_high_output_reg <= 1'b0;
      timer_low_output_reg <= 1'b0;
    end else begin
      timer_high_output_reg <= tctrl_reg.run && high_phase_reg &&
        (!tctrl_reg.style || half_fast_reg);
      timer_low_output_reg <= tctrl_reg.run && !high_phase_reg &&
        (!tctrl_reg.style || half_fast_reg);
    end
  end

  assign timer_high_output = timer_high_output_reg;
  assign timer_low_output = timer_low_output_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hwp_meta_reg <= 1'b0;
      hwp_sync_reg <= 1'b0;
    end else begin
      hwp_meta_reg <= hw_pause_pin;
      hwp_sync_reg <= hwp_meta_reg;
    end
  end

  ttpwm_triple #(
    .W(W)
  ) u_triple (
    .pclk(pclk),
    .presetn(presetn),
    .ctrl(pctrl_reg),
    .period(period_reg),
    .duty({duty_c_reg, duty_b_reg, duty_a_reg}),
    .hw_pause(hwp_sync_reg),
    .pwm_out(pwm_out),
    .paused()
  );

  assign channel_a_output = pwm_out[0];
  assign channel_b_output = pwm_out[1];
  assign channel_c_output = pwm_out[2];

  sequence s_stopped;
    !tctrl_reg.run;
  endsequence

  sequence s_high_end;
    tctrl_reg.run && timer_tick && high_phase_reg && phase_counter_reg == 16'h0000;
  endsequence

  a_stop_holds_reset: assert property (@(posedge pclk) disable iff (!presetn)
    s_stopped ##1 s_stopped |-> phase_counter_reg == $past(high_phase_value_reg) &&
    high_phase_reg && !timer_high_output_reg)
    else $error("Stopped timer left its reset state.");
  a_phase_to_low: assert property (@(posedge pclk) disable iff (!presetn)
    s_high_end |=> !high_phase_reg && phase_counter_reg == $past(low_phase_value_reg))
    else $error("High phase did not reload from the low value.");
  a_clock_select: assert property (@(posedge pclk) disable iff (!presetn)
    tctrl_reg.run && !tctrl_reg.fast_sel && !slow_tick && phase_counter_reg != 16'h0000
    ##1 tctrl_reg.run |-> $stable(phase_counter_reg))
    else $error("Phase counter moved without a slow tick.");
  a_prescale_on: assert property (@(posedge pclk) disable iff (!presetn)
    tctrl_reg.run && !tctrl_reg.bypass && timer_tick && pre_reg != PW'(PRESCALE - 1)
    |=> $stable(on_period_counter_reg))
    else $error("On counter ignored the prescaler.");
  a_style_level: assert property (@(posedge pclk) disable iff (!presetn)
    tctrl_reg.run && !tctrl_reg.style && high_phase_reg |=> timer_high_output_reg)
    else $error("High phase output not steady one.");
  a_style_clock: assert property (@(posedge pclk) disable iff (!presetn)
    tctrl_reg.run && tctrl_reg.style && high_phase_reg |=> timer_high_output_reg == $past(half_fast_reg))
    else $error("High phase output not the halved fast clock.");
  a_on_readback: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == A_ON |=> prdata == {16'h0000, $past(on_period_counter_reg)})
    else $error("On register read did not return the live count.");
  a_phase_readback: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && (paddr == A_HI || paddr == A_LO) |=> prdata == {16'h0000, $past(phase_counter_reg)})
    else $error("Reload register read did not return the phase count.");
  a_duty_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == A_DB |=> duty_b_reg == $past(pwdata[W-1:0]))
    else $error("Duty write lost.");
endmodule
`default_nettype wire

// [ttpwm_triple.sv]
// Three-channel PWM sharing one period counter.
// Assumes hw_pause is already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
module ttpwm_triple #(
  parameter int W = ttpwm_pkg::DUTY_W
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Settings.
  input wire ttpwm_pkg::ttpwm_pctrl_t ctrl,
  input wire logic [W-1:0] period,
  input wire logic [3*W-1:0] duty,
  input wire logic hw_pause,
  // Outputs.
  output logic [2:0] pwm_out,
  output logic paused
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [2:0] out_next;

  // A pause freezes the count and the outputs so that a pulse resumes where it stopped.
  assign paused = ctrl.sw_pause | (ctrl.hw_allow & hw_pause);
  assign cnt_next = (cnt_reg >= period) ? '0 : cnt_reg + 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (!ctrl.enable) begin
      cnt_reg <= '0;
    end else if (!paused) begin
      cnt_reg <= cnt_next;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      assign out_next[g] = ctrl.enable && (cnt_reg < duty[g*W +: W]);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 3'h0;
    end else if (!ctrl.enable) begin
      pwm_out <= 3'h0;
    end else if (!paused) begin
      pwm_out <= out_next;
    end
  end

  a_disabled_low: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl.enable |=> pwm_out == 3'h0 && cnt_reg == '0)
    else $error("Outputs active while disabled.");
  a_pause_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.enable && ctrl.sw_pause ##1 ctrl.enable |-> $stable(cnt_reg))
    else $error("Period count moved while paused.");
  a_hw_pause_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.enable && !ctrl.sw_pause && !ctrl.hw_allow && cnt_reg < period |=> cnt_reg != $past(cnt_reg))
    else $error("Hardware pause took effect without permission.");
  a_wrap_period: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.enable && !paused && cnt_reg >= period |=> cnt_reg == '0)
    else $error("Period count did not wrap.");
  a_ch_compare: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.enable && !paused |=> pwm_out[0] == ($past(cnt_reg) < $past(duty[W-1:0])))
    else $error("Channel output disagrees with compare.");
endmodule
`default_nettype wire
